// file: design/nibble_add_group.sv
/*
 Add-family execution slice of a 4-bit core: decodes add, add-with-carry and
 carry-keeping adds, holds the accumulator, carry and zero flags and data memory.
 Assumes one instruction presented per cycle with insn_valid, synchronous to clk_sys.
 Instructions outside the add family are ignored here and change no state; another
 slice of the core executes them. Data memory is cleared by reset, so the working
 registers and every nibble read as zero until an add stores into them. The peek
 port is a debug read path and never disturbs execution.
*/
// Functional notes
// - Memory add: acc gets mem plus acc; memory kept; carry and zero updated.
// - Immediate add: acc gets wreg plus immediate; wreg kept; carry, zero updated.
// - Storing memory add writes the sum to acc and memory; carry, zero updated.
// - Storing immediate add writes the sum to acc and wreg; carry, zero updated.
// - Storing carry-in immediate add: wreg+imm+carry to acc and wreg; flags updated.
// - Carry-keeping memory add: sum to acc, zero updated, carry kept.
// - Carry-keeping immediate add: sum to acc, wreg kept, zero only.
// - Storing carry-keeping memory add: sum to acc and memory, zero only.
// - Storing carry-keeping immediate add: sum to wreg and acc, zero only.
`timescale 1ns/10ps
module nibble_add_group
	import nibble_add_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	// Instruction
	input  wire logic              insn_valid,
	input  wire logic [INSN_W-1:0] insn,
	// Architectural state
	output logic      [NIB_W-1:0]  result_nibble_reg,
	output logic                   carry_flag,
	output logic                   zero_flag,
	// Status
	output logic                   insn_done,
	output logic                   insn_known,
	// Memory peek port
	input  wire logic [ADDR_W-1:0] peek_addr,
	output logic      [NIB_W-1:0]  peek_data
);
	// Storage: data memory with the working registers at its foot, then the
	// accumulator, the two flags and the status pipeline
	logic [NIB_W-1:0] mem_r [MEM_N];
	logic [NIB_W-1:0] acc_r;
	logic             carry_r;
	logic             zero_r;
	logic             done_r;
	logic             known_r;
	logic [NIB_W-1:0] peek_r;

	// Field extraction; the memory and working-register forms share the low
	// bits of the word, so both addresses are formed here and the decode
	// below picks the one that applies
	wire logic [7:0]        opc;
	wire logic [NIB_W-1:0]  imm;
	wire logic [ADDR_W-1:0] mem_adr;
	wire logic [ADDR_W-1:0] wreg_adr;
	assign opc      = insn[OPC_LSB +: 8];
	assign imm      = insn[IMM_LSB +: NIB_W];
	assign mem_adr  = insn[MADR_LSB +: ADDR_W];
	assign wreg_adr = WREG_BASE | {3'b000, insn[WSEL_LSB +: NIB_W]};

	// One match line per add-family opcode, so that a code of another
	// instruction group that shares some opcode bits can never slip through
	// a partial bit test and change the accumulator
	wire logic m_cin_mem;
	wire logic m_cin_imm;
	wire logic m_cins_mem;
	wire logic m_cins_imm;
	wire logic m_add_mem;
	wire logic m_add_imm;
	wire logic m_adds_mem;
	wire logic m_adds_imm;
	wire logic m_keep_mem;
	wire logic m_keep_imm;
	wire logic m_keeps_mem;
	wire logic m_keeps_imm;
	assign m_cin_mem   = (opc == OP_ADC_MEM);
	assign m_cin_imm   = (opc == OP_ADC_IMM);
	assign m_cins_mem  = (opc == OP_ADCS_MEM);
	assign m_cins_imm  = (opc == OP_ADCS_IMM);
	assign m_add_mem   = (opc == OP_ADD_MEM);
	assign m_add_imm   = (opc == OP_ADD_IMM);
	assign m_adds_mem  = (opc == OP_ADDS_MEM);
	assign m_adds_imm  = (opc == OP_ADDS_IMM);
	assign m_keep_mem  = (opc == OP_KEEP_MEM);
	assign m_keep_imm  = (opc == OP_KEEP_IMM);
	assign m_keeps_mem = (opc == OP_KEEPS_MEM);
	assign m_keeps_imm = (opc == OP_KEEPS_IMM);

	// Any of the twelve codes is an add of this group
	wire logic hit;
	assign hit = m_cin_mem | m_cin_imm | m_cins_mem | m_cins_imm |
		m_add_mem | m_add_imm | m_adds_mem | m_adds_imm |
		m_keep_mem | m_keep_imm | m_keeps_mem | m_keeps_imm;

	// Operation class from the opcode bits; only meaningful while hit is
	// high, which every use below checks through exec
	wire logic is_imm;
	wire logic is_store;
	wire logic use_cin;
	wire logic keep_carry;
	assign is_imm     = opc[2];                       // Bit 2 picks wreg+immediate
	assign is_store   = opc[0];                       // Bit 0 stores back
	assign use_cin    = (opc[5:4] == 2'b00);          // Carry-in group
	assign keep_carry = opc[5];                       // Carry kept

	// Operand selection: the first operand always comes from data memory,
	// either the addressed nibble or the working register; the second is
	// the accumulator for memory forms and the immediate for register forms
	wire logic [ADDR_W-1:0] src_adr;
	wire logic [NIB_W-1:0]  src_val;
	wire logic [NIB_W-1:0]  other_val;
	assign src_adr   = is_imm ? wreg_adr : mem_adr;
	assign src_val   = mem_r[src_adr];
	assign other_val = is_imm ? imm : acc_r;

	// Four-bit adder; carry-in is masked for every group but add-with-carry,
	// so a stale carry cannot leak into a plain or carry-keeping add
	wire logic [NIB_W-1:0] sum;
	wire logic             cout;
	wire logic             sum_zero;
	wire logic             cin_used;
	assign cin_used = use_cin & carry_r;
	nibble_sum u_sum (
		.op_a    (src_val),
		.op_b    (other_val),
		.cin     (cin_used),
		.sum     (sum),
		.cout    (cout),
		.is_zero (sum_zero)
	);

	// Execution strobe; every add of the group completes in the cycle it is
	// presented, and a back-to-back add sees the result of the one before
	wire logic exec;
	wire logic mem_we;
	assign exec   = insn_valid & hit;                    // One cycle per instruction
	assign mem_we = exec & is_store;

	// Status pipeline; one-cycle pulses that mark an executed add
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			done_r  <= 1'b0;
			known_r <= 1'b0;
		end
		else
		begin
			done_r  <= exec;
			known_r <= insn_valid & hit;
		end
	end

	// Accumulator and flags; carry is written only by the carry-updating
	// groups, zero by every add of the family
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			acc_r   <= ACC_RST;
			carry_r <= FLAG_RST;
			zero_r  <= FLAG_RST;
		end
		else
		begin
			if (exec)
			begin
				acc_r  <= sum;
				zero_r <= sum_zero;
				if (!keep_carry)
					carry_r <= cout;
			end
		end
	end

	// Data memory, one entry per nibble, written back only by the storing
	// adds; cleared by reset so that the first operand read after start-up
	// is defined and an unknown cannot spread into the accumulator and carry
	genvar gi;
	generate
		for (gi = 0; gi < MEM_N; gi = gi + 1)
		begin : g_mem
			wire logic we_here;
			assign we_here = mem_we && (src_adr == ADDR_W'(gi));
			always_ff @(posedge clk_sys or negedge nrst)
			begin
				if (!nrst)
					mem_r[gi] <= MEM_RST;
				else if (we_here)
					mem_r[gi] <= sum;
			end
		end
	endgenerate

	// Registered peek read; shows the entry as it stood before any write
	// landing on the same edge, so a store is seen one cycle later
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
			peek_r <= MEM_RST;
		else
			peek_r <= mem_r[peek_addr];
	end

	// Outputs come straight from the registers
	assign result_nibble_reg = acc_r;
	assign carry_flag        = carry_r;
	assign zero_flag         = zero_r;
	assign insn_done         = done_r;
	assign insn_known        = known_r;
	assign peek_data         = peek_r;
endmodule : nibble_add_group

// file: design/nibble_add_pkg.sv
/*
 Constants for the nibble add group: opcode fields, working-register layout, reset values.
 Assumes a 16-bit instruction word with the opcode in bits 15..8.
*/
package nibble_add_pkg;
	localparam int unsigned NIB_W     = 4;
	localparam int unsigned ADDR_W    = 7;
	localparam int unsigned INSN_W    = 16;
	localparam int unsigned WREG_N    = 16;
	localparam int unsigned MEM_N     = 128;
	// Opcode byte values
	localparam logic [7:0] OP_ADC_MEM    = 8'h08;
	localparam logic [7:0] OP_ADC_IMM    = 8'h0c;
	localparam logic [7:0] OP_ADCS_MEM   = 8'h09;
	localparam logic [7:0] OP_ADCS_IMM   = 8'h0d;
	localparam logic [7:0] OP_ADD_MEM    = 8'h18;
	localparam logic [7:0] OP_ADD_IMM    = 8'h1c;
	localparam logic [7:0] OP_ADDS_MEM   = 8'h19;
	localparam logic [7:0] OP_ADDS_IMM   = 8'h1d;
	localparam logic [7:0] OP_KEEP_MEM   = 8'h28;
	localparam logic [7:0] OP_KEEP_IMM   = 8'h2c;
	localparam logic [7:0] OP_KEEPS_MEM  = 8'h29;
	localparam logic [7:0] OP_KEEPS_IMM  = 8'h2d;
	// Field positions inside the instruction word
	localparam int unsigned OPC_LSB   = 8;
	localparam int unsigned IMM_LSB   = 4;
	localparam int unsigned WSEL_LSB  = 0;
	localparam int unsigned MADR_LSB  = 0;
	// Working registers sit at the bottom of data memory
	localparam logic [6:0] WREG_BASE  = 7'h00;
	// Reset values
	localparam logic [3:0] ACC_RST    = 4'h0;
	localparam logic       FLAG_RST   = 1'b0;
	localparam logic [3:0] MEM_RST    = 4'h0;
endpackage : nibble_add_pkg

// file: design/nibble_sum.sv
/*
 Four-bit adder with carry-in, carry-out and zero detect.
 Pure combinational; caller selects operands.
*/
`timescale 1ns/10ps
module nibble_sum
	import nibble_add_pkg::*;
(
	// Operands
	input  wire logic [NIB_W-1:0] op_a,
	input  wire logic [NIB_W-1:0] op_b,
	input  wire logic             cin,
	// Result
	output wire logic [NIB_W-1:0] sum,
	output wire logic             cout,
	output wire logic             is_zero
);
	wire logic [NIB_W:0] full_sum;

	// Sum modulo sixteen, carry from bit 3
	assign full_sum = {1'b0, op_a} + {1'b0, op_b} + {{NIB_W{1'b0}}, cin};
	assign sum      = full_sum[NIB_W-1:0];
	assign cout     = full_sum[NIB_W];
	assign is_zero  = (full_sum[NIB_W-1:0] == 4'h0);
endmodule : nibble_sum

// file: test/nibble_add_group_assertions.sv
/* Port checker for the nibble add group.
 Assumes the bench points peek_addr at the operand of each instruction. */
`timescale 1ns/10ps
module nibble_add_group_assertions
	import nibble_add_pkg::*;
(
	input wire logic              clk_sys, nrst, insn_valid, carry_flag, zero_flag,
	input wire logic              insn_done, insn_known,
	input wire logic [INSN_W-1:0] insn,
	input wire logic [NIB_W-1:0]  result_nibble_reg, peek_data,
	input wire logic [ADDR_W-1:0] peek_addr
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic       hit, chk_r, st_r, kc_r, cin_r;
	logic [3:0] b_r;
	logic [4:0] s;
	// Add opcode decode and the sum expected from the peeked operand
	assign hit = insn_valid && insn[15:12] < 4'h3 && insn[11] && !insn[9];
	assign s   = 5'(peek_data) + 5'(b_r) + 5'(cin_r);
	// Operands captured at the executing edge
	always_ff @(posedge clk_sys or negedge nrst)
		if (!nrst)
			{chk_r, st_r, kc_r, cin_r, b_r} <= '0;
		else
		begin
			chk_r <= hit && peek_addr == (insn[10] ? {3'h0, insn[3:0]} : insn[6:0]);
			st_r  <= insn[8];
			kc_r  <= insn[13];
			cin_r <= insn[15:12] == 4'h0 && carry_flag;
			b_r   <= insn[10] ? insn[7:4] : result_nibble_reg;
		end
	a_sum_result: assert property (chk_r |-> result_nibble_reg == s[3:0])
		else $error("accumulator sum wrong");
	a_carry_update: assert property (chk_r && !kc_r |-> carry_flag == s[4])
		else $error("carry out wrong");
	a_keep_carry: assert property (hit && insn[13] |=> $stable(carry_flag))
		else $error("carry changed");
	a_zero_flag: assert property (insn_done |-> zero_flag == (result_nibble_reg == 4'h0))
		else $error("zero flag wrong");
	a_done_pulse: assert property (hit |=> insn_done && insn_known)
		else $error("done missing");
	a_refuse_idle: assert property (!hit |=> !insn_done && $stable(result_nibble_reg)
		&& $stable(carry_flag) && $stable(zero_flag))
		else $error("state changed when idle");
	a_mem_effect: assert property (chk_r && $stable(peek_addr) |=> peek_data ==
		(st_r ? $past(result_nibble_reg) : $past(peek_data)))
		else $error("memory write wrong");
	a_known_done: assert property (insn_known == insn_done)
		else $error("known and done differ");
	c_store: cover property (chk_r && st_r);
	c_keep: cover property (chk_r && kc_r);
	c_carry_in: cover property (chk_r && cin_r);
endmodule : nibble_add_group_assertions
bind nibble_add_group nibble_add_group_assertions u_chk (.clk_sys(clk_sys), .nrst(nrst),
	.insn_valid(insn_valid), .carry_flag(carry_flag), .zero_flag(zero_flag), .insn(insn),
	.insn_done(insn_done), .insn_known(insn_known), .result_nibble_reg(result_nibble_reg),
	.peek_data(peek_data), .peek_addr(peek_addr));

// file: test/nibble_add_group_tb.sv
/* Random add-family instructions and the non-add code 8'h2a, checked against a bench model.
 Assumes memory operands are learnt through the peek port. */
`timescale 1ns/10ps
module nibble_add_group_tb;
	import nibble_add_pkg::*;
	logic        clk_sys = 0, nrst = 0, insn_valid = 0, cf, zf, done, known;
	logic [15:0] insn = '0;
	logic [6:0]  peek_addr = '0;
	logic [3:0]  acc, peek, opnd, a_old;
	logic [4:0]  s;
	logic [7:0]  ops [13] = '{8'h08, 8'h09, 8'h0c, 8'h0d, 8'h18, 8'h19, 8'h1c, 8'h1d,
		8'h28, 8'h29, 8'h2c, 8'h2d, 8'h2a};
	int          err_count = 0, total_checks = 0;
	nibble_add_group DUT (.clk_sys(clk_sys), .nrst(nrst), .insn_valid(insn_valid),
		.insn(insn), .result_nibble_reg(acc), .carry_flag(cf), .zero_flag(zf),
		.insn_done(done), .insn_known(known), .peek_addr(peek_addr), .peek_data(peek));
	always #5 clk_sys = ~clk_sys;
	// Count a comparison and report a miss
	task chk(input logic ok, input string m);
		total_checks++;
		if (ok !== 1'b1)
		begin
			$display("mismatch %0t %s", $time, m);
			err_count++;
		end
	endtask : chk
	// Expected five-bit sum of two nibbles and a carry-in
	function automatic logic [4:0] exp_sum(input logic [3:0] a, input logic [3:0] b,
		input logic c);
		return 5'(a) + 5'(b) + 5'(c);
	endfunction : exp_sum
	// One instruction, then its flags, accumulator and memory effect
	task exec(input logic [7:0] op, input logic [7:0] lo);
		logic hit, cf_old, zf_old;
		hit = op[7:4] < 4'h3 && op[3] && !op[1];
		@(negedge clk_sys);
		{cf_old, zf_old, a_old} = {cf, zf, acc};
		insn = {op, lo};
		insn_valid = 1;
		peek_addr = op[2] ? {3'h0, lo[3:0]} : lo[6:0];
		@(negedge clk_sys);
		insn_valid = 0;
		opnd = peek;
		s = exp_sum(opnd, op[2] ? lo[7:4] : a_old, op[7:4] == 4'h0 && cf_old);
		chk(acc === (hit ? s[3:0] : a_old), "acc");
		chk(cf === (hit && !op[5] ? s[4] : cf_old), "carry");
		chk(zf === (hit ? s[3:0] == 4'h0 : zf_old), "zero");
		chk(done === hit, "done");
		chk(known === hit, "known");
		@(negedge clk_sys);
		chk(peek === (hit && op[0] ? s[3:0] : opnd), "memory");
	endtask : exec
	// Verdict and end of run
	task finish_test;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : finish_test
	initial
	begin
		void'($urandom(68));
		repeat (6) @(negedge clk_sys);
		nrst = 1;
		foreach (ops[i]) exec(ops[i], 8'hff);
		repeat (300) exec(ops[$urandom_range(12)], 8'($urandom));
		finish_test();
	end
endmodule : nibble_add_group_tb
